// ---- cstat_top.sv ----
// common status register: gp inputs, interrupt mask, two sticky fault flags
// assumes a serial bus front end delivers decoded byte reads and writes on the clock
`timescale 1ns/1ps
`default_nettype none
`include "cstat_defines.svh"
module cstat_top
    import cstat_pkg::*;
(
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic SLOT_A_GP_INPUT_IN,
    input wire logic SLOT_B_GP_INPUT_IN,
    input wire logic SUPPLY_LOCKOUT_FAULT_IN,
    input wire logic SLOT_A_POWER_REQ_IN,
    input wire logic SLOT_B_POWER_REQ_IN,
    input wire logic SLOT_A_MAIN_CTRL_IN,
    input wire logic SLOT_B_MAIN_CTRL_IN,
    input wire logic OVERTEMP_FAULT_IN,
    output logic [7:0] RDATA_OUT,
    output logic RVALID_OUT,
    output logic IRQ_N_OUT,
    output logic ALERT_ARB_EN_OUT
);
    logic rst_s1_q;
    logic rst_n_q;
    logic irq_mask_bit_q;
    logic undervoltage_flag;
    logic overtemp_flag;
    logic hit_wr;
    logic uv_set;
    logic any_power;
    // whole reset byte kept typed so the mask bit is picked, not truncated
    localparam cstat_byte_t reset_byte = `CSTAT_RESET_VALUE;

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    assign hit_wr = WR_IN && (ADDR_IN == `CSTAT_ADDR_COMMON);
    // lockout only counts while a slot wants main power
    assign any_power = SLOT_A_POWER_REQ_IN || SLOT_B_POWER_REQ_IN
        || SLOT_A_MAIN_CTRL_IN || SLOT_B_MAIN_CTRL_IN;
    assign uv_set = SUPPLY_LOCKOUT_FAULT_IN && any_power;

    always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_mask_bit_q <= reset_byte[`CSTAT_BIT_MASK];
        end else if (hit_wr) begin
            irq_mask_bit_q <= WDATA_IN[`CSTAT_BIT_MASK];
        end
    end

    cstat_flag u_uv (
        .clk_in(CLOCK_IN),
        .rst_n_in(rst_n_q),
        .set_in(uv_set),
        .clear_in(hit_wr && WDATA_IN[`CSTAT_BIT_UV]),
        .flag_out(undervoltage_flag)
    );

    cstat_flag u_ot (
        .clk_in(CLOCK_IN),
        .rst_n_in(rst_n_q),
        .set_in(OVERTEMP_FAULT_IN),
        .clear_in(hit_wr && WDATA_IN[`CSTAT_BIT_OT]),
        .flag_out(overtemp_flag)
    );

    // read data registered; unmapped offsets read zero
    always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            RDATA_OUT <= 8'h00;
            RVALID_OUT <= 1'b0;
        end else begin
            RVALID_OUT <= RD_IN;
            RDATA_OUT <= 8'h00;
            if (RD_IN && ADDR_IN == `CSTAT_ADDR_COMMON) begin
                RDATA_OUT[`CSTAT_BIT_GPI_B] <= SLOT_B_GP_INPUT_IN;
                RDATA_OUT[`CSTAT_BIT_GPI_A] <= SLOT_A_GP_INPUT_IN;
                RDATA_OUT[`CSTAT_BIT_MASK] <= irq_mask_bit_q;
                RDATA_OUT[`CSTAT_BIT_UV] <= undervoltage_flag;
                RDATA_OUT[`CSTAT_BIT_OT] <= overtemp_flag;
            end
        end
    end

    // one cycle behind the flags, so a clear releases on the next edge
    always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            IRQ_N_OUT <= 1'b1;
            ALERT_ARB_EN_OUT <= 1'b0;
        end else begin
            IRQ_N_OUT <= !((undervoltage_flag || overtemp_flag) && !irq_mask_bit_q);
            ALERT_ARB_EN_OUT <= !irq_mask_bit_q && (undervoltage_flag || overtemp_flag);
        end
    end

    property p_mask_blocks_irq;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        irq_mask_bit_q |=> IRQ_N_OUT;
    endproperty
    a_mask_blocks_irq: assert property (p_mask_blocks_irq) else $error("irq with mask set");

    property p_mask_no_arb;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        irq_mask_bit_q |=> !ALERT_ARB_EN_OUT;
    endproperty
    a_mask_no_arb: assert property (p_mask_no_arb) else $error("arbitration while masked");

    property p_uv_sets;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        uv_set |=> undervoltage_flag;
    endproperty
    a_uv_sets: assert property (p_uv_sets) else $error("uv flag not set");

    property p_uv_needs_power;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        (!undervoltage_flag && !(SUPPLY_LOCKOUT_FAULT_IN && any_power)) |=> !undervoltage_flag;
    endproperty
    a_uv_needs_power: assert property (p_uv_needs_power) else $error("uv set without cause");

    property p_ot_sets;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        OVERTEMP_FAULT_IN |=> overtemp_flag ##1 (overtemp_flag || $past(hit_wr));
    endproperty
    a_ot_sets: assert property (p_ot_sets) else $error("ot flag not set");

    property p_flag_sticky;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        (overtemp_flag && !(hit_wr && WDATA_IN[`CSTAT_BIT_OT])) |=> overtemp_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("ot flag dropped");

    property p_clear;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        (hit_wr && WDATA_IN[`CSTAT_BIT_UV] && !uv_set) |=> !undervoltage_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("uv flag not cleared");

    property p_irq_follows;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        ((undervoltage_flag || overtemp_flag) && !irq_mask_bit_q) |=> !IRQ_N_OUT;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not asserted");

    property p_irq_release;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        !((undervoltage_flag || overtemp_flag) && !irq_mask_bit_q) |=> IRQ_N_OUT;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq stuck");

    property p_arb_follows;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        ((undervoltage_flag || overtemp_flag) && !irq_mask_bit_q) |=> ALERT_ARB_EN_OUT;
    endproperty
    a_arb_follows: assert property (p_arb_follows) else $error("arb not offered");

    property p_ot_needs_fault;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        (!overtemp_flag && !OVERTEMP_FAULT_IN) |=> !overtemp_flag;
    endproperty
    a_ot_needs_fault: assert property (p_ot_needs_fault) else $error("ot without cause");

    property p_uv_sticky;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        (undervoltage_flag && !(hit_wr && WDATA_IN[`CSTAT_BIT_UV])) |=> undervoltage_flag;
    endproperty
    a_uv_sticky: assert property (p_uv_sticky) else $error("uv flag dropped");

    property p_ot_clear;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        (hit_wr && WDATA_IN[`CSTAT_BIT_OT] && !OVERTEMP_FAULT_IN) |=> !overtemp_flag;
    endproperty
    a_ot_clear: assert property (p_ot_clear) else $error("ot flag not cleared");

    property p_gp_live;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        (RD_IN && ADDR_IN == `CSTAT_ADDR_COMMON) |=>
            (RDATA_OUT[`CSTAT_BIT_GPI_B] == $past(SLOT_B_GP_INPUT_IN))
            && (RDATA_OUT[`CSTAT_BIT_GPI_A] == $past(SLOT_A_GP_INPUT_IN));
    endproperty
    a_gp_live: assert property (p_gp_live) else $error("gp bit not live");

    // reserved and undefined bits read zero so hosts can compare whole bytes
    property p_reserved_zero;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        RVALID_OUT |-> (RDATA_OUT[7:6] == 2'h0) && !RDATA_OUT[0];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_unmapped_zero;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        !(RD_IN && ADDR_IN == `CSTAT_ADDR_COMMON) |=> (RDATA_OUT == 8'h00);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("stray read data");

    // fixed one-cycle answer; the host never waits on a handshake
    property p_rvalid_follows;
        @(posedge CLOCK_IN) disable iff (!rst_n_q)
        RD_IN |=> RVALID_OUT;
    endproperty
    a_rvalid_follows: assert property (p_rvalid_follows) else $error("read not answered");

    c_uv_irq: cover property (@(posedge CLOCK_IN) uv_set ##2 !IRQ_N_OUT);
    c_ot_clear: cover property (@(posedge CLOCK_IN) overtemp_flag ##1 hit_wr ##1 !overtemp_flag);
    c_masked: cover property (@(posedge CLOCK_IN) irq_mask_bit_q && overtemp_flag);
    c_uv_clear: cover property (@(posedge CLOCK_IN)
        undervoltage_flag ##1 hit_wr ##1 !undervoltage_flag);
    c_unmask_irq: cover property (@(posedge CLOCK_IN)
        (irq_mask_bit_q && overtemp_flag) ##1 !irq_mask_bit_q ##1 !IRQ_N_OUT);
endmodule : cstat_top
`default_nettype wire

// ---- cstat_defines.svh ----
// register offset, field positions and reset value of the common status register
// assumes inclusion by bare name from cstat_top
`ifndef CSTAT_DEFINES_SVH
`define CSTAT_DEFINES_SVH
`define CSTAT_ADDR_COMMON 8'h06
`define CSTAT_RESET_VALUE 8'h00
`define CSTAT_BIT_GPI_B 5
`define CSTAT_BIT_GPI_A 4
`define CSTAT_BIT_MASK 3
`define CSTAT_BIT_UV 2
`define CSTAT_BIT_OT 1
`endif

// ---- cstat_pkg.sv ----
// types shared by the common status register block
// assumes nothing of its surroundings
`default_nettype none
package cstat_pkg;
    typedef logic [7:0] cstat_byte_t;
endpackage : cstat_pkg
`default_nettype wire

// ---- cstat_flag.sv ----
// one sticky fault flag with write-one-to-clear
// assumes synchronous event and write strobe inputs
`timescale 1ns/1ps
`default_nettype none
module cstat_flag (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_out
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1; // set beats clear
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule : cstat_flag
`default_nettype wire

// ---- cstat_host_model.sv ----
// host side of the decoded byte bus: strobed reads and writes
// assumes the bench calls its tasks between clock edges
`timescale 1ns/1ps
`default_nettype none
module cstat_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
    end
    // one write strobe; a 1 in a flag bit clears it
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in) {addr_out, wdata_out, wr_out} <= {a, d, 1'b1};
        @(posedge clk_in) wr_out <= 1'b0;
    endtask : wr
    // answer is due exactly one cycle after the strobe
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in) {addr_out, rd_out} <= {a, 1'b1};
        @(posedge clk_in) rd_out <= 1'b0;
        // valid stands one cycle; take it at the edge that samples it high
        @(posedge clk_in) d = rvalid_in ? rdata_in : 8'hxx;
    endtask : rd
endmodule : cstat_host_model
`default_nettype wire

// ---- common_status_register_tb_top.sv ----
// self-checking bench for the common status register
// assumes the host model drives the byte bus and the bench drives fault pins
`timescale 1ns/1ps
`default_nettype none
module common_status_register_tb_top;
    import cstat_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] ev = 8'h00; // gpb gpa ctlb ctla reqb reqa uv ot
    wire logic [7:0] addr;
    wire logic [7:0] wdata;
    wire logic wr;
    wire logic rd;
    cstat_byte_t rdata;
    logic rvalid, irq_n, arb;
    logic [7:0] v;
    int miscompares = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    cstat_top i_dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd),
        .WDATA_IN(wdata), .SLOT_A_GP_INPUT_IN(ev[6]), .SLOT_B_GP_INPUT_IN(ev[7]),
        .SUPPLY_LOCKOUT_FAULT_IN(ev[1]), .SLOT_A_POWER_REQ_IN(ev[2]), .SLOT_B_POWER_REQ_IN(ev[3]),
        .SLOT_A_MAIN_CTRL_IN(ev[4]), .SLOT_B_MAIN_CTRL_IN(ev[5]), .OVERTEMP_FAULT_IN(ev[0]),
        .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .IRQ_N_OUT(irq_n), .ALERT_ARB_EN_OUT(arb));
    cstat_host_model i_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        chk(v, exp);
    endtask : rchk
    task ichk(input logic [1:0] exp); // irq_n, arb
        repeat (2) @(posedge clk);
        #1 chk({6'h0, irq_n, arb}, {6'h0, exp});
    endtask : ichk
    task pulse(input int b);
        @(posedge clk) ev[b] <= 1'b1;
        @(posedge clk) ev[b] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    initial begin
        #100000 miscompares++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(8'h06, 8'h00);
        ichk(2'b10);
        @(posedge clk) ev <= 8'h40;
        rchk(8'h06, 8'h10);
        @(posedge clk) ev <= 8'h80;
        rchk(8'h06, 8'h20);
        @(posedge clk) ev <= 8'h00;
        $display("gp test done");
        pulse(0);
        rchk(8'h06, 8'h02);
        ichk(2'b01);
        i_host.wr(8'h06, 8'h08);
        ichk(2'b10);
        rchk(8'h06, 8'h0a);
        i_host.wr(8'h06, 8'h00);
        ichk(2'b01);
        i_host.wr(8'h06, 8'h02);
        ichk(2'b10);
        rchk(8'h06, 8'h00);
        $display("overtemp test done");
        pulse(1);
        rchk(8'h06, 8'h00);
        for (int i = 2; i < 6; i++) begin
            @(posedge clk) ev[i] <= 1'b1;
            pulse(1);
            ev[i] <= 1'b0;
            rchk(8'h06, 8'h04);
            ichk(2'b01);
            i_host.wr(8'h06, 8'h04);
            ichk(2'b10);
            rchk(8'h06, 8'h00);
        end
        $display("undervoltage test done");
        i_host.wr(8'h07, 8'hff);
        rchk(8'h07, 8'h00);
        rchk(8'h06, 8'h00);
        $display("unmapped test done");
        i_host.wr(8'h06, 8'hff);
        rchk(8'h06, 8'h08);
        i_host.wr(8'h06, 8'h00);
        rchk(8'h06, 8'h00);
        $display("reserved bits test done");
        stop_test();
    end
endmodule : common_status_register_tb_top
`default_nettype wire
